// file: rtl/omsc_defs.vh
// Constants for the operating-mode and system-control register bank
`ifndef OMSC_DEFS_VH
`define OMSC_DEFS_VH
`define OMSC_ADDR_W 4
`define OMSC_OFS_MODE_MON 4'h0
`define OMSC_OFS_SYS_CTRL 4'h1
`define OMSC_OFS_BUS_CFG 4'h2
`define OMSC_OFS_STATUS 4'h3
`define OMSC_MODE1 3'h1
`define OMSC_MODE2 3'h2
`define OMSC_MODE3 3'h3
`define OMSC_MODE4 3'h4
`define OMSC_MODE7 3'h7
`define OMSC_SC_RSV7 7
`define OMSC_SC_RSV6 6
`define OMSC_SC_MAC_SATURATE_SELECT 5
`define OMSC_SC_RSV4 4
`define OMSC_SC_FLSHMAP 3
`define OMSC_SC_RSV2 2
`define OMSC_SC_EXTERNAL_BUS_ENABLE 1
`define OMSC_SC_ONCHIP_RAM_ENABLE 0
`define OMSC_SC_RESET 8'hC1
`define OMSC_SC_WMASK 8'hFB
`define OMSC_BUS_CFG_RESET 8'hFF
`define OMSC_FLASH_LO 24'hFFFEB0
`define OMSC_FLASH_HI 24'hFFFEB3
`endif

// file: rtl/omsc_sync3.v
// Three-stage input synchroniser for the mode pins and the reset pin
`timescale 1ns/1ps
module omsc_sync3 #(
  parameter W = 3
) (
  input wire sys_clk, // Core clock
  input wire rst, // Asynchronous reset
  input wire [W-1:0] din, // Asynchronous input
  output reg [W-1:0] dout // Filtered level
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  // Chain; output moves once stages two and three agree
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule

// file: rtl/omsc_top.v
// Operating-mode selection and system-control register bank
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "omsc_defs.vh"
//
// Behaviour
// RULE_01: Mode pins 001,010,011,100,111 select modes 1,2,3,4,7; advanced CPU.
// RULE_02: Board keeps mode pins constant during operation.
// RULE_03: On-chip ROM off in modes 1,2; on in modes 3,4,7.
// RULE_04: Data bus starts 16 bits in mode 1, 8 in 2 and 4; max 16.
// RULE_05: Expanded bus is 16-bit if any area 16-bit, else 8-bit.
// RULE_06: Mode 7 starts single-chip; software may open the external bus.
// RULE_07: Mode 3 is boot mode permitting flash program and erase.
// RULE_08: ROM-less parts are strapped only to mode 1 or 2.
// RULE_09: Mode monitor bits 7..3 read zero, writes ignored.
// RULE_10: Mode monitor bits 2..0 read-only, mirror mode pins 2..0.
// RULE_11: Mode monitor latches pins when read; reset clears latch.
// RULE_12: Software keeps control bits 7,6 at one and bit 4 at zero.
// RULE_13: Control bit 5 resets zero; selects MAC saturation.
// RULE_14: Control bit 3 maps flash registers at FFFEB0..FFFEB3; contents kept.
// RULE_15: Parts without flash get zero written to the map bit.
// RULE_16: Control bit 2 reads zero, ignores writes.
// RULE_17: Control bit 1 is read/write external bus enable.
// RULE_18: Reset pin low halts, initialises, masks interrupts; rising edge starts.
// RULE_19: Watchdog overflow resets exactly like the reset pin.
// RULE_20: Control bit 0 resets one; enables on-chip RAM.
// RULE_21: Mode 7 external enable opens expanded mode, all areas 16-bit.
// RULE_22: External enable resets one in modes 1,2,4; zero in 3,7.
module omsc_top #(
  parameter AREAS = 8
) (
  input wire sys_clk, // Core clock, 250 MHz
  input wire rst, // Asynchronous reset, active high
  input wire reset_n_pin, // Reset pin, active low, async
  input wire wdt_overflow, // Watchdog overflow pulse
  input wire mode_pin_2, // Mode strap 2
  input wire mode_pin_1, // Mode strap 1
  input wire mode_pin_0, // Mode strap 0
  input wire [`OMSC_ADDR_W-1:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [7:0] reg_rdata, // Read data, cycle after strobe
  input wire [23:0] cpu_addr, // CPU address for flash decode
  output reg core_reset, // Internal reset to CPU and peripherals
  output reg irq_mask_all, // All interrupts masked
  output reg reset_exc_start, // Reset exception start pulse
  output reg [2:0] op_mode, // Decoded mode number, 0 if invalid
  output reg mode_valid, // Strap is a legal mode
  output reg advanced_mode, // CPU advanced mode
  output reg onchip_rom_en, // On-chip ROM enabled
  output reg boot_mode, // Flash boot mode
  output reg single_chip, // Single-chip operation
  output reg ext_bus_16, // External bus runs 16-bit
  output reg mac_saturate_select, // MAC saturation
  output reg flash_ctrl_map_enable, // Flash control map bit
  output reg flash_ctrl_sel, // Flash control registers selected
  output reg external_bus_enable, // External bus enabled
  output reg onchip_ram_enable // On-chip RAM enabled
);
  // ************************************************************
  // Internal state and wiring
  // ************************************************************
  wire [2:0] pins_sync;
  wire [0:0] rstpin_sync;
  reg [2:0] mode_latch_reg;
  reg [7:0] sys_ctrl_reg;
  reg [AREAS-1:0] bus16_reg;
  reg strap_done_reg;
  reg [2:0] strap_reg;
  reg wdt_reset_reg;
  reg pin_low_d_reg;
  wire pin_low;
  wire in_reset;
  wire wr_ok;
  wire wr_sc;
  wire wr_bus;
  wire [2:0] mode_num;

  // ************************************************************
  // Decoding functions
  // ************************************************************
  // Decode strap into mode number, zero when illegal
  function [2:0] omsc_decode;
    input [2:0] p;
    begin
      case (p)
        `OMSC_MODE1: omsc_decode = 3'h1; // RULE_01
        `OMSC_MODE2: omsc_decode = 3'h2; // RULE_01
        `OMSC_MODE3: omsc_decode = 3'h3; // RULE_01
        `OMSC_MODE4: omsc_decode = 3'h4; // RULE_01
        `OMSC_MODE7: omsc_decode = 3'h7; // RULE_01
        default: omsc_decode = 3'h0;
      endcase
    end
  endfunction

  // Register address decode for writes and monitor reads
  function hit;
    input [`OMSC_ADDR_W-1:0] a;
    input [`OMSC_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Modes that run with on-chip ROM enabled
  function omsc_rom_on;
    input [2:0] m;
    begin
      omsc_rom_on = (m == `OMSC_MODE3) | (m == `OMSC_MODE4) |
        (m == `OMSC_MODE7);
    end
  endfunction

  // Expanded modes, external bus enabled out of reset
  function omsc_ext_default;
    input [2:0] m;
    begin
      omsc_ext_default = (m == `OMSC_MODE1) | (m == `OMSC_MODE2) |
        (m == `OMSC_MODE4);
    end
  endfunction

  // Only mode 1 starts with every area 16 bits wide
  function omsc_wide_default;
    input [2:0] m;
    begin
      omsc_wide_default = (m == `OMSC_MODE1);
    end
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  omsc_sync3 #(.W(3)) u_pins (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({mode_pin_2, mode_pin_1, mode_pin_0}),
    .dout(pins_sync)
  );

  omsc_sync3 #(.W(1)) u_rstpin (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(reset_n_pin),
    .dout(rstpin_sync)
  );

  // ************************************************************
  // Reset sources and write decode
  // ************************************************************
  // Synchroniser clears to zero, so the pin counts as low until seen high
  assign pin_low = ~rstpin_sync[0];
  assign in_reset = pin_low | wdt_reset_reg; // RULE_18 RULE_19
  assign mode_num = omsc_decode(strap_reg);
  // Writes refused until the core has left reset
  assign wr_ok = reg_wr & ~core_reset;
  assign wr_sc = wr_ok & hit(reg_addr, `OMSC_OFS_SYS_CTRL);
  assign wr_bus = wr_ok & hit(reg_addr, `OMSC_OFS_BUS_CFG);
  // No write path to the mode monitor or status offsets

  // ************************************************************
  // Reset control
  // ************************************************************
  // Watchdog overflow held for one cycle of internal reset
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wdt_reset_reg <= 1'b0;
      pin_low_d_reg <= 1'b1;
    end
    else
    begin
      wdt_reset_reg <= wdt_overflow; // RULE_19
      pin_low_d_reg <= in_reset;
    end
  end

  // Strap captured while in reset from synchronised pins
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_reg <= 3'h0;
      strap_done_reg <= 1'b0;
    end
    else if (in_reset | ~strap_done_reg)
    begin
      strap_reg <= pins_sync; // RULE_02
      strap_done_reg <= 1'b1;
    end
  end

  // Core held and interrupts masked while any reset source is active
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      core_reset <= 1'b1;
      irq_mask_all <= 1'b1;
    end
    else
    begin
      core_reset <= in_reset | ~strap_done_reg; // RULE_18
      irq_mask_all <= in_reset | ~strap_done_reg; // RULE_18
    end
  end

  // One-cycle start pulse as internal reset ends
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reset_exc_start <= 1'b0;
    else
      reset_exc_start <= pin_low_d_reg & ~in_reset & strap_done_reg; // RULE_18
  end

  // ************************************************************
  // Mode monitor
  // ************************************************************
  // Mode monitor latch, loaded on each read of the monitor offset
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mode_latch_reg <= 3'h0;
    else if (in_reset)
      mode_latch_reg <= 3'h0; // RULE_11
    else if (reg_rd & hit(reg_addr, `OMSC_OFS_MODE_MON))
      mode_latch_reg <= pins_sync; // RULE_11 RULE_10
  end

  // ************************************************************
  // System control
  // ************************************************************
  // System control and bus area widths
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_ctrl_reg <= `OMSC_SC_RESET;
      bus16_reg <= {AREAS{1'b1}};
    end
    else if (in_reset | ~strap_done_reg)
    begin
      sys_ctrl_reg <= `OMSC_SC_RESET; // RULE_13 RULE_20 RULE_12
      // RULE_22
      sys_ctrl_reg[`OMSC_SC_EXTERNAL_BUS_ENABLE] <= omsc_ext_default(mode_num);
      // RULE_04
      bus16_reg <= {AREAS{omsc_wide_default(mode_num)}};
    end
    else
    begin
      if (wr_sc)
      begin
        // RULE_16 RULE_17 RULE_14
        sys_ctrl_reg <= reg_wdata & `OMSC_SC_WMASK;
        if ((mode_num == 3'h7) & reg_wdata[`OMSC_SC_EXTERNAL_BUS_ENABLE] &
            ~sys_ctrl_reg[`OMSC_SC_EXTERNAL_BUS_ENABLE])
          bus16_reg <= {AREAS{1'b1}}; // RULE_21
      end
      if (wr_bus)
        bus16_reg <= reg_wdata[AREAS-1:0];
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  // Register read path, one cycle after the strobe
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        // RULE_09 RULE_10
        `OMSC_OFS_MODE_MON: reg_rdata <= {5'h00, pins_sync};
        `OMSC_OFS_SYS_CTRL: reg_rdata <= sys_ctrl_reg;
        `OMSC_OFS_BUS_CFG: reg_rdata <= bus16_reg;
        `OMSC_OFS_STATUS: reg_rdata <= {ext_bus_16, single_chip,
          boot_mode, onchip_rom_en, mode_valid, op_mode};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ************************************************************
  // Mode and control outputs
  // ************************************************************
  // Outputs decoded from the captured strap
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      op_mode <= 3'h0;
      mode_valid <= 1'b0;
      advanced_mode <= 1'b1;
      onchip_rom_en <= 1'b0;
      boot_mode <= 1'b0;
    end
    else
    begin
      op_mode <= mode_num; // RULE_01
      mode_valid <= (mode_num != 3'h0);
      advanced_mode <= 1'b1; // RULE_01
      onchip_rom_en <= omsc_rom_on(mode_num); // RULE_03
      boot_mode <= (mode_num == `OMSC_MODE3); // RULE_07
    end
  end

  // Bus operation follows the enable bit and the area widths
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      single_chip <= 1'b0;
      ext_bus_16 <= 1'b0;
      external_bus_enable <= 1'b0;
    end
    else
    begin
      // RULE_06 RULE_21
      single_chip <= ~sys_ctrl_reg[`OMSC_SC_EXTERNAL_BUS_ENABLE];
      ext_bus_16 <= sys_ctrl_reg[`OMSC_SC_EXTERNAL_BUS_ENABLE] & (|bus16_reg); // RULE_05
      external_bus_enable <= sys_ctrl_reg[`OMSC_SC_EXTERNAL_BUS_ENABLE]; // RULE_17
    end
  end

  // Control bits mirrored one cycle late
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mac_saturate_select <= 1'b0;
      flash_ctrl_map_enable <= 1'b0;
      onchip_ram_enable <= 1'b1;
    end
    else
    begin
      mac_saturate_select <= sys_ctrl_reg[`OMSC_SC_MAC_SATURATE_SELECT]; // RULE_13
      flash_ctrl_map_enable <= sys_ctrl_reg[`OMSC_SC_FLSHMAP];
      onchip_ram_enable <= sys_ctrl_reg[`OMSC_SC_ONCHIP_RAM_ENABLE]; // RULE_20
    end
  end

  // Flash control window, only while the map bit is set
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      flash_ctrl_sel <= 1'b0;
    else
      // RULE_14
      flash_ctrl_sel <= sys_ctrl_reg[`OMSC_SC_FLSHMAP] &
        (cpu_addr >= `OMSC_FLASH_LO) & (cpu_addr <= `OMSC_FLASH_HI);
  end
endmodule

// file: verification/omsc_asserts.sv
// Port checker for the mode and system-control register bank
`timescale 1ns/1ps
module omsc_asserts (
  input wire sys_clk, // Clock
  input wire rst, // Reset
  input wire wdt_overflow, // Watchdog
  input wire mode_pin_2, // Strap 2
  input wire mode_pin_1, // Strap 1
  input wire mode_pin_0, // Strap 0
  input wire [3:0] reg_addr, // Address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_rdata, // Read data
  input wire core_reset, // Core reset
  input wire irq_mask_all, // Irq mask
  input wire onchip_rom_en, // ROM on
  input wire mac_saturate_select, // MAC sat
  input wire onchip_ram_enable // RAM on
);
  wire [2:0] pins = {mode_pin_2, mode_pin_1, mode_pin_0};
  wire mon_rd = reg_rd && reg_addr == 4'h0;
  wire ctl_rd = reg_rd && reg_addr == 4'h1;
  wire ctl_wr = reg_wr && reg_addr == 4'h1 && !core_reset;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // Properties
  // ****
  property p_mon_hi; mon_rd |=> reg_rdata[7:3] == 5'h00; endproperty
  a_mon_hi: assert property (p_mon_hi) else $error("monitor high");
  property p_mon_lo; mon_rd |=> reg_rdata[2:0] == $past(pins); endproperty
  a_mon_lo: assert property (p_mon_lo) else $error("monitor pins");
  property p_b2; ctl_rd |=> !reg_rdata[2]; endproperty
  a_b2: assert property (p_b2) else $error("control bit2");
  property p_rom;
    !core_reset && !$past(core_reset) |->
      onchip_rom_en == (pins inside {3'h3, 3'h4, 3'h7});
  endproperty
  a_rom: assert property (p_rom) else $error("rom enable");
  property p_mac; ctl_wr |=> ##1 mac_saturate_select == $past(reg_wdata[5], 2);
  endproperty
  a_mac: assert property (p_mac) else $error("mac select");
  property p_ram; ctl_wr |=> ##1 onchip_ram_enable == $past(reg_wdata[0], 2);
  endproperty
  a_ram: assert property (p_ram) else $error("ram enable");
  property p_wdt; wdt_overflow |-> ##[1:3] core_reset; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset");
  property p_irq; core_reset |-> irq_mask_all; endproperty
  a_irq: assert property (p_irq) else $error("irq unmasked");
  c_mon: cover property (mon_rd);
  c_wr: cover property (ctl_wr);
  c_wdt: cover property (wdt_overflow);
endmodule
bind omsc_top omsc_asserts i_omsc_asserts (.sys_clk, .rst, .wdt_overflow,
  .mode_pin_2, .mode_pin_1, .mode_pin_0, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .core_reset, .irq_mask_all, .onchip_rom_en,
  .mac_saturate_select, .onchip_ram_enable);

// file: verification/omsc_board.sv
// Board model: mode straps and reset pin
`timescale 1ns/1ps
module omsc_board (
  input wire sys_clk, // Clock
  input wire rst, // Bench reset
  input wire [2:0] strap, // Wanted mode
  input wire reset_req, // Pin reset request
  output reg mode_pin_2, // Strap 2
  output reg mode_pin_1, // Strap 1
  output reg mode_pin_0, // Strap 0
  output reg reset_n_pin // Reset pin
);
  reg [3:0] cnt_reg;
  // Pin low 13 cycles; straps move only mid-reset
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      cnt_reg <= 4'hC;
      reset_n_pin <= 1'b0;
      {mode_pin_2, mode_pin_1, mode_pin_0} <= strap;
    end
    else
    begin
      cnt_reg <= reset_req ? 4'hC : cnt_reg - {3'h0, cnt_reg != 4'h0};
      reset_n_pin <= cnt_reg == 4'h0 && !reset_req;
      if (cnt_reg == 4'h6)
        {mode_pin_2, mode_pin_1, mode_pin_0} <= strap;
    end
endmodule

// file: verification/omsc_tb_top.sv
// Self-checking bench for the mode and system-control register bank
`timescale 1ns/1ps
module omsc_tb_top;
  logic sys_clk, rst, reset_req, wdt_overflow, reg_wr, reg_rd, reset_n_pin;
  logic mode_pin_2, mode_pin_1, mode_pin_0, core_reset, irq_mask_all;
  logic advanced_mode, onchip_rom_en, boot_mode, single_chip, ext_bus_16;
  logic mac_saturate_select, flash_ctrl_map_enable, flash_ctrl_sel;
  logic external_bus_enable, onchip_ram_enable, reset_exc_start, mode_valid;
  logic [2:0] strap, op_mode, s;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [23:0] cpu_addr;
  logic [19:0] rows [0:4];
  int miscompares = 0;
  int samples_checked = 0;
  int i;
  omsc_board i_omsc_board (.sys_clk, .rst, .strap, .reset_req, .mode_pin_2,
    .mode_pin_1, .mode_pin_0, .reset_n_pin);
  omsc_top i_omsc_top (.sys_clk, .rst, .reset_n_pin, .wdt_overflow,
    .mode_pin_2, .mode_pin_1, .mode_pin_0, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cpu_addr, .core_reset, .irq_mask_all,
    .reset_exc_start, .op_mode, .mode_valid, .advanced_mode,
    .onchip_rom_en, .boot_mode, .single_chip, .ext_bus_16,
    .mac_saturate_select, .flash_ctrl_map_enable, .flash_ctrl_sel,
    .external_bus_enable, .onchip_ram_enable);
  // ****
  // Tasks
  // ****
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task step_addr(input logic [23:0] a);
    @(posedge sys_clk);
    cpu_addr <= a;
    repeat (2) @(negedge sys_clk);
  endtask
  task pin_reset;
    @(posedge sys_clk);
    strap <= s;
    reset_req <= 1'b1;
    @(posedge sys_clk);
    reset_req <= 1'b0;
    repeat (12) @(negedge sys_clk);
    chk({7'h00, irq_mask_all & core_reset}, 8'h01);
    for (i = 0; i < 50 && core_reset !== 1'b0; i++)
      @(negedge sys_clk);
    chk({7'h00, core_reset}, 8'h00);
    chk({7'h00, reset_exc_start}, 8'h01);
  endtask
  task final_report;
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #40000;
    miscompares++;
    final_report;
  end
  // Rows: strap, control reset, bus config reset, ROM enable
  initial
  begin
    rows = '{{3'h1, 8'hC3, 8'hFF, 1'h0}, {3'h2, 8'hC3, 8'h00, 1'h0},
      {3'h3, 8'hC1, 8'h00, 1'h1}, {3'h4, 8'hC3, 8'h00, 1'h1},
      {3'h7, 8'hC1, 8'h00, 1'h1}};
    rst = 1'b1;
    strap = 3'h1;
    {reset_req, wdt_overflow, reg_wr, reg_rd} = 4'h0;
    {reg_addr, reg_wdata, cpu_addr} = 36'h000000000;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int r = 0; r < 5; r++)
    begin
      s = rows[r][19:17];
      pin_reset;
      rd(4'h0);
      chk(d, {5'h00, s});
      rd(4'h1);
      chk(d, rows[r][16:9]);
      rd(4'h2);
      chk(d, rows[r][8:1]);
      rd(4'h3);
      chk(d, {rows[r][1], !rows[r][10], s == 3'h3, rows[r][0], 1'h1,
        s});
      chk({7'h00, mode_valid}, 8'h01);
      chk({op_mode, boot_mode, single_chip, ext_bus_16, onchip_rom_en,
        advanced_mode}, {s, s == 3'h3, !rows[r][10], rows[r][1],
        rows[r][0], 1'h1});
    end
    // Mode 7 opening the external bus
    wr(4'h1, 8'hC3);
    rd(4'h2);
    chk(d, 8'hFF);
    chk({6'h00, single_chip, ext_bus_16}, 8'h01);
    wr(4'h2, 8'h00);
    chk({7'h00, ext_bus_16}, 8'h00);
    wr(4'h2, 8'h10);
    chk({7'h00, ext_bus_16}, 8'h01);
    // Read-only monitor, reserved bit, unmapped place
    wr(4'h0, 8'hFF);
    rd(4'h0);
    chk(d, 8'h07);
    rd(4'hF);
    chk(d, 8'h00);
    wr(4'h1, 8'hEF);
    rd(4'h1);
    chk(d, 8'hEB);
    chk({4'h0, mac_saturate_select, flash_ctrl_map_enable,
      external_bus_enable, onchip_ram_enable}, 8'h0F);
    // Flash window edges with the map bit set
    for (int k = 0; k < 6; k++)
    begin
      step_addr(24'hFFFEAF + k);
      chk({7'h00, flash_ctrl_sel}, {7'h00, k > 0 && k < 5});
    end
    wr(4'h1, 8'hE0);
    step_addr(24'hFFFEB0);
    chk({7'h00, flash_ctrl_sel}, 8'h00);
    chk({6'h00, mac_saturate_select, onchip_ram_enable}, 8'h02);
    // Watchdog overflow restores defaults
    @(posedge sys_clk);
    wdt_overflow <= 1'b1;
    @(posedge sys_clk);
    wdt_overflow <= 1'b0;
    repeat (8) @(negedge sys_clk);
    rd(4'h1);
    chk(d, 8'hC1);
    final_report;
  end
endmodule
